// [hdl/tpcc_pkg.sv]
// constants for the t1 channel payload conditioning block
package tpcc_pkg;
	localparam int NUM_CH = 24;
	// register indices, printed offsets; byte address is four times the index
	localparam logic [7:0] TX_CTRL_BASE = 8'h01;
	localparam logic [7:0] DTRK_BASE = 8'h21;
	localparam logic [7:0] STRK_BASE = 8'h41;
	// banks: tx set at bit 8 of index clear, rx set at bit 8 set
	localparam logic [8:0] RX_BANK = 9'h100;
	localparam logic [8:0] GLOBAL_CTRL_IDX = 9'h0f0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STRK_RESET = 8'h00;
	// signaling trunk code field positions
	localparam int STRK_TEST_BIT = 6;
	localparam int STRK_SIGNALING_INSERT_ENABLE_BIT = 5;
	localparam int STRK_EN_BIT = 4;
	localparam logic [7:0] STRK_RX_MASK = 8'h5f;
	localparam logic [7:0] STRK_TX_MASK = 8'h7f;
	// global control fields
	localparam int G_SUBST_LSB = 0;
	localparam int G_STRK_BIT = 6;
	localparam int G_PRBS_MODE_LSB = 3;
	localparam int G_PRBS_DIR_BIT = 8;
	localparam int G_RX_PRBS_DIR_BIT = 9;
	localparam int G_CLK_MASTER_BIT = 10;
	localparam int G_PER_CHANNEL_CLOCK_ENABLE_BIT = 11;
	localparam logic [1:0] PRBS_MODE_8BIT = 2'h1;
	localparam logic [1:0] PRBS_MODE_7BIT = 2'h2;
	localparam logic [2:0] SUB_NONE = 3'h0;
	localparam logic [2:0] SUB_TRUNK = 3'h1;
	localparam logic [2:0] SUB_ALAW = 3'h2;
	localparam logic [2:0] SUB_ULAW = 3'h3;
	localparam logic [2:0] SUB_LOOP = 3'h4;
	localparam int FIFO_DEPTH = 4;
	localparam logic [22:0] PRBS_SEED = 23'h7fffff;
endpackage

// [hdl/tpcc_fifo.sv]
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module tpcc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic rdy_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	// ready is kept in a flip-flop, worked out from the next count
	assign in_ready_o = rdy_q;
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem_q[rd_q];
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data_i;
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_d;
			rdy_q <= cnt_d != (AW+1)'(DEPTH);
		end
	end
endmodule // tpcc_fifo

// [hdl/tpcc_top.sv]
// per-channel payload conditioning for a 24-channel t1 stream
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module tpcc_top #(
	parameter int NUM_CH = 24
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [11:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// channel byte streams, one byte per valid
	input wire logic [4:0] tx_ch_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic [3:0] tx_sig_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [7:0] loop_byte_i,
	input wire logic [4:0] rx_ch_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic [3:0] rx_sig_i,
	input wire logic rx_valid_i,
	output logic [7:0] tx_byte_o,
	output logic [3:0] tx_sig_o,
	output logic tx_sig_ins_o,
	output logic [7:0] tx_clk_gap_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] rx_byte_o,
	output logic [3:0] rx_sig_o,
	output logic rx_valid_o,
	output logic prbs_bit_o,
	output logic prbs_bit_valid_o,
	output logic prbs_sync_o
);
	localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
		8'hb4, 8'ha1, 8'ha1, 8'hb4};
	localparam logic [7:0] ULAW_MW [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
		8'h9e, 8'h8b, 8'h8b, 8'h9e};

	logic [7:0] tx_ctrl_q [NUM_CH];
	logic [7:0] tx_dtrk_q [NUM_CH];
	logic [7:0] tx_strk_q [NUM_CH];
	logic [7:0] rx_dtrk_q [NUM_CH];
	logic [7:0] rx_strk_q [NUM_CH];
	logic [11:0] glob_q;
	logic [2:0] mw_q;
	logic [22:0] gen_q;
	logic [22:0] det_q;
	logic [3:0] det_good_q;
	logic [31:0] dat_q;
	logic ack_q;

	// bit 1 (msb) has the highest index; pattern union
	function automatic logic [7:0] inv_mask(input logic [7:0] ctrl);
		inv_mask = (ctrl[4] ? 8'h80 : 8'h00) | (ctrl[3] ? 8'h2a : 8'h00)
			| (ctrl[2] ? 8'h55 : 8'h00);
	endfunction

	// one prbs step, x^23 + x^18 + 1
	function automatic logic [22:0] prbs_step(input logic [22:0] s);
		prbs_step = {s[21:0], s[22] ^ s[17]};
	endfunction

	// channel index from a per-channel register index
	function automatic logic [4:0] ch_of(input logic [7:0] idx, input logic [7:0] base);
		logic [7:0] d;
		d = idx - base;
		ch_of = d[4:0];
	endfunction

	function automatic logic in_set(input logic [7:0] idx, input logic [7:0] base);
		in_set = idx >= base && idx < base + 8'(NUM_CH);
	endfunction

	// bus decode, index is the word address
	wire [8:0] widx = adr_i[10:2];
	wire [7:0] lidx = widx[7:0];
	wire is_rx = widx[8];
	wire bus_req = cyc_i && stb_i && !ack_q;
	wire wr_lo = bus_req && we_i && sel_i[0];
	wire hit_ctrl = !is_rx && in_set(lidx, tpcc_pkg::TX_CTRL_BASE);
	wire hit_dtrk = in_set(lidx, tpcc_pkg::DTRK_BASE);
	wire hit_strk = in_set(lidx, tpcc_pkg::STRK_BASE);
	wire hit_glob = widx == tpcc_pkg::GLOBAL_CTRL_IDX;
	wire [4:0] c_ctrl = ch_of(lidx, tpcc_pkg::TX_CTRL_BASE);
	wire [4:0] c_dtrk = ch_of(lidx, tpcc_pkg::DTRK_BASE);
	wire [4:0] c_strk = ch_of(lidx, tpcc_pkg::STRK_BASE);
	wire [7:0] rd_byte = hit_ctrl ? tx_ctrl_q[c_ctrl]
		: hit_dtrk ? (is_rx ? rx_dtrk_q[c_dtrk] : tx_dtrk_q[c_dtrk])
		: hit_strk ? (is_rx ? rx_strk_q[c_strk] : tx_strk_q[c_strk]) : 8'h00;
	wire [31:0] rd_word = hit_glob ? {20'h00000, glob_q} : {24'h000000, rd_byte};

	// global settings
	wire [2:0] g_subst = glob_q[tpcc_pkg::G_SUBST_LSB +: 3];
	wire g_strk = glob_q[tpcc_pkg::G_STRK_BIT];
	wire [1:0] prbs_mode = glob_q[tpcc_pkg::G_PRBS_MODE_LSB +: 2];
	wire prbs_dir = glob_q[tpcc_pkg::G_PRBS_DIR_BIT];
	wire rx_prbs_dir = glob_q[tpcc_pkg::G_RX_PRBS_DIR_BIT];
	wire clk_master = glob_q[tpcc_pkg::G_CLK_MASTER_BIT];
	wire per_channel_clock_enable = glob_q[tpcc_pkg::G_PER_CHANNEL_CLOCK_ENABLE_BIT];
	wire mode8 = prbs_mode == tpcc_pkg::PRBS_MODE_8BIT;
	wire mode_on = mode8 || prbs_mode == tpcc_pkg::PRBS_MODE_7BIT;
	// 8-bit mode covers every bit, 7-bit mode only the msbs
	wire [7:0] prbs_lanes = mode8 ? 8'hff : 8'hfe;

	// transmit path sits behind the fifo
	wire [16:0] f_out;
	wire f_valid;
	wire f_ready;
	tpcc_fifo #(.WIDTH(17), .DEPTH(tpcc_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i({tx_ch_i, tx_sig_i, tx_byte_i}),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_ready_o),
		.out_data_o(f_out),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready)
	);
	wire [4:0] t_ch = f_out[16:12];
	wire [3:0] t_sig = f_out[11:8];
	wire [7:0] t_byte = f_out[7:0];
	assign f_ready = !tx_valid_o || tx_ready_i;
	wire t_go = f_valid && f_ready;
	wire [7:0] t_ctrl = tx_ctrl_q[t_ch];
	wire [7:0] t_strk = tx_strk_q[t_ch];
	wire [2:0] t_sel = (g_subst == tpcc_pkg::SUB_NONE) ? t_ctrl[7:5] : g_subst;
	wire t_test = mode_on && t_strk[tpcc_pkg::STRK_TEST_BIT];
	wire t_overwrite = t_test && !prbs_dir;
	wire t_detect = t_test && prbs_dir;
	wire t_strk_on = g_strk || t_strk[tpcc_pkg::STRK_EN_BIT];

	// substitution then inversion
	logic [7:0] t_sub;
	always_comb begin
		unique case (t_sel)
			tpcc_pkg::SUB_TRUNK: t_sub = tx_dtrk_q[t_ch];
			tpcc_pkg::SUB_ALAW: t_sub = ALAW_MW[mw_q];
			tpcc_pkg::SUB_ULAW: t_sub = ULAW_MW[mw_q];
			tpcc_pkg::SUB_LOOP: t_sub = loop_byte_i;
			default: t_sub = t_byte;
		endcase
	end
	wire [7:0] t_inv = t_sub ^ inv_mask(t_ctrl);

	// receive path
	wire [7:0] r_strk = rx_strk_q[rx_ch_i];
	wire r_test = mode_on && r_strk[tpcc_pkg::STRK_TEST_BIT];
	wire r_overwrite = r_test && rx_prbs_dir;
	wire r_detect = r_test && !rx_prbs_dir;
	wire r_strk_on = g_strk || r_strk[tpcc_pkg::STRK_EN_BIT];

	function automatic logic [22:0] prbs_step8(input logic [22:0] s);
		logic [22:0] v;
		v = s;
		for (int i = 0; i < 8; i++) v = prbs_step(v);
		prbs_step8 = v;
	endfunction
	function automatic logic [22:0] prbs_step7(input logic [22:0] s);
		logic [22:0] v;
		v = s;
		for (int i = 0; i < 7; i++) v = prbs_step(v);
		prbs_step7 = v;
	endfunction

	// generator feeds overwrite channels on either side from one shared stream
	wire tx_ow = t_go && t_overwrite;
	wire rx_ow = rx_valid_i && r_overwrite;
	wire [7:0] gen_tx = gen_q[22:15];
	wire [22:0] gen_after_tx = tx_ow ? (mode8 ? prbs_step8(gen_q) : prbs_step7(gen_q)) : gen_q;
	wire [7:0] gen_rx = gen_after_tx[22:15];
	wire [22:0] gen_d = rx_ow ? (mode8 ? prbs_step8(gen_after_tx) : prbs_step7(gen_after_tx))
		: gen_after_tx;

	// detector: one byte of test data per cycle, serialised msb first into the checker
	wire det_take = (t_go && t_detect) || (rx_valid_i && r_detect);
	wire [7:0] det_byte = (t_go && t_detect) ? t_byte : rx_byte_i;
	logic [22:0] det_d;
	logic det_err;
	always_comb begin
		det_d = det_q;
		det_err = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (prbs_lanes[i]) begin
				det_err = det_err | (det_byte[i] != (det_d[22] ^ det_d[17]));
				det_d = {det_d[21:0], det_byte[i]};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
			glob_q <= '0;
			mw_q <= '0;
			gen_q <= tpcc_pkg::PRBS_SEED;
			det_q <= '0;
			det_good_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				tx_ctrl_q[i] <= tpcc_pkg::CTRL_RESET;
				tx_dtrk_q[i] <= tpcc_pkg::CTRL_RESET;
				tx_strk_q[i] <= tpcc_pkg::STRK_RESET;
				rx_dtrk_q[i] <= tpcc_pkg::CTRL_RESET;
				rx_strk_q[i] <= tpcc_pkg::STRK_RESET;
			end
		end else begin
			ack_q <= bus_req;
			dat_q <= bus_req ? rd_word : '0;
			if (wr_lo && hit_glob)
				glob_q[7:0] <= dat_i[7:0];
			if (bus_req && we_i && sel_i[1] && hit_glob)
				glob_q[11:8] <= dat_i[11:8];
			if (wr_lo && hit_ctrl)
				tx_ctrl_q[c_ctrl] <= dat_i[7:0];
			if (wr_lo && hit_dtrk && !is_rx)
				tx_dtrk_q[c_dtrk] <= dat_i[7:0];
			if (wr_lo && hit_dtrk && is_rx)
				rx_dtrk_q[c_dtrk] <= dat_i[7:0];
			if (wr_lo && hit_strk && !is_rx)
				tx_strk_q[c_strk] <= dat_i[7:0] & tpcc_pkg::STRK_TX_MASK;
			if (wr_lo && hit_strk && is_rx)
				rx_strk_q[c_strk] <= dat_i[7:0] & tpcc_pkg::STRK_RX_MASK;
			if (t_go && (t_sel == tpcc_pkg::SUB_ALAW || t_sel == tpcc_pkg::SUB_ULAW))
				mw_q <= mw_q + 3'h1;
			gen_q <= gen_d;
			if (det_take) begin
				det_q <= det_d;
				det_good_q <= det_err ? 4'h0 : (det_good_q == 4'hf ? det_good_q : det_good_q + 4'h1);
			end
		end
	end
	assign dat_o = dat_q;
	assign ack_o = ack_q;

	// output registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_valid_o <= 1'b0;
			tx_byte_o <= '0;
			tx_sig_o <= '0;
			tx_sig_ins_o <= 1'b0;
			tx_clk_gap_o <= '0;
			rx_valid_o <= 1'b0;
			rx_byte_o <= '0;
			rx_sig_o <= '0;
			prbs_bit_o <= 1'b0;
			prbs_bit_valid_o <= 1'b0;
			prbs_sync_o <= 1'b0;
		end else begin
			if (f_ready)
				tx_valid_o <= f_valid;
			if (t_go) begin
				tx_byte_o <= t_overwrite ? ((t_inv & ~prbs_lanes) | (gen_tx & prbs_lanes)) : t_inv;
				tx_sig_o <= t_strk_on ? t_strk[3:0] : t_sig;
				tx_sig_ins_o <= t_strk[tpcc_pkg::STRK_SIGNALING_INSERT_ENABLE_BIT];
				tx_clk_gap_o <= !(clk_master && per_channel_clock_enable) ? 8'h00
					: t_ctrl[0] ? 8'hff : t_ctrl[1] ? 8'h01 : 8'h00;
			end
			rx_valid_o <= rx_valid_i;
			if (rx_valid_i) begin
				rx_byte_o <= r_overwrite ? ((rx_byte_i & ~prbs_lanes) | (gen_rx & prbs_lanes))
					: rx_byte_i;
				rx_sig_o <= r_strk_on ? r_strk[3:0] : rx_sig_i;
			end
			prbs_bit_valid_o <= det_take;
			if (det_take)
				prbs_bit_o <= det_err;
			prbs_sync_o <= det_good_q == 4'hf;
		end
	end
endmodule // tpcc_top

// [sim/tpcc_props.sv]
// port checker for the payload conditioning block
`timescale 1ns/1ps
module tpcc_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic rx_valid_i,
	input wire logic rx_valid_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] tx_byte_o,
	input wire logic [3:0] tx_sig_o,
	input wire logic [7:0] tx_clk_gap_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_due; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_due: assert property (p_ack_due) else $error("no ack");
	property p_ack_why; ack_o |-> $past(cyc_i && stb_i); endproperty
	a_ack_why: assert property (p_ack_why) else $error("stray ack");
	property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data idle");
	property p_rx_due; rx_valid_i |=> rx_valid_o; endproperty
	a_rx_due: assert property (p_rx_due) else $error("rx byte lost");
	property p_rx_why; rx_valid_o |-> $past(rx_valid_i); endproperty
	a_rx_why: assert property (p_rx_why) else $error("stray rx byte");
	property p_tx_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_byte_o, tx_sig_o, tx_clk_gap_o});
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx changed in stall");
	property p_gap; tx_valid_o |-> tx_clk_gap_o inside {8'h00, 8'h01, 8'hff}; endproperty
	a_gap: assert property (p_gap) else $error("gap mask shape");
	c_ack: cover property (ack_o);
	c_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_valid_o);
	c_gap: cover property (tx_valid_o && tx_clk_gap_o == 8'hff);
	c_rx: cover property (rx_valid_o ##1 rx_valid_o);
endmodule // tpcc_props

bind tpcc_top tpcc_props i_tpcc_props (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
	.rx_valid_i, .rx_valid_o, .tx_valid_o, .tx_ready_i, .tx_byte_o, .tx_sig_o, .tx_clk_gap_o);

// [sim/tpcc_far_model.sv]
// far side: downstream ready with random stalls, loopback byte
`timescale 1ns/1ps
module tpcc_far_model #(
	parameter logic [7:0] LOOP = 8'h3c
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hold_i,
	output logic ready_o = 1'b0,
	output logic [7:0] loop_o
);
	int sd = 32'h52a1c7e9;
	// receive store byte held steady so its use can be predicted
	assign loop_o = LOOP;
	always @(posedge clk_i) begin
		ready_o <= !rst_i && !hold_i && ($random(sd) % 4 != 0);
	end
endmodule // tpcc_far_model

// [sim/test_tpcc_top.sv]
// self-checking bench for the payload conditioning block
`timescale 1ns/1ps
module test_tpcc_top;
	localparam logic [7:0] LOOPB = 8'h3c;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, tx_valid_i, rx_valid_i, tx_ready_i, hold, rxon, ok;
	logic tx_ready_o, ack_o, tx_sig_ins_o, tx_valid_o, rx_valid_o, gstk, gm, gp;
	logic [2:0] gsub;
	logic [3:0] sel_i, tx_sig_i, rx_sig_i, tx_sig_o, rx_sig_o;
	logic [4:0] tx_ch_i, rx_ch_i;
	logic [7:0] tx_byte_i, rx_byte_i, loop_byte_i, tx_byte_o, tx_clk_gap_o, rx_byte_o;
	logic [7:0] ctl[24], dtk[24], stk[24], rtk[24];
	logic [11:0] adr_i, re;
	logic [21:0] te;
	logic [22:0] gen = tpcc_pkg::PRBS_SEED;
	logic [22:0] src = tpcc_pkg::PRBS_SEED;
	logic [7:0] rb, pl;
	logic [1:0] gmode = 2'h0;
	logic pbit, pvld, psync;
	logic [31:0] dat_i, dat_o, rd;
	logic [21:0] txq[$];
	logic [11:0] rxq[$];
	int err_total, n_checks, seed, cnt, ndet, npv;
	tpcc_top i_tpcc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o,
		.ack_o, .tx_ch_i, .tx_byte_i, .tx_sig_i, .tx_valid_i, .tx_ready_o, .loop_byte_i, .rx_ch_i,
		.rx_byte_i, .rx_sig_i, .rx_valid_i, .tx_byte_o, .tx_sig_o, .tx_sig_ins_o, .tx_clk_gap_o,
		.tx_valid_o, .tx_ready_i, .rx_byte_o, .rx_sig_o, .rx_valid_o, .prbs_bit_o(pbit),
		.prbs_bit_valid_o(pvld), .prbs_sync_o(psync));
	tpcc_far_model #(.LOOP(LOOPB)) i_tpcc_far_model (.clk_i, .rst_i, .hold_i(hold),
		.ready_o(tx_ready_i), .loop_o(loop_byte_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [8:0] ix, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'h3;
		adr_i <= {1'b0, ix, 2'b00};
		dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [8:0] ix, input logic [7:0] e);
		wb(1'b0, ix, 32'h0);
		chk(nm, 32'(e), rd);
	endtask
	// reference test sequence, x^23 + x^18 + 1, n bits on
	function automatic logic [22:0] lfsr(input logic [22:0] s, input int n);
		for (int i = 0; i < n; i++) s = {s[21:0], s[22] ^ s[17]};
		return s;
	endfunction
	// skip flag for milliwatt codes, insert, gap mask, abcd, byte
	function automatic logic [21:0] texp(input int c, input logic [7:0] b, input logic [3:0] s);
		logic [2:0] k;
		logic [7:0] m, g;
		k = gsub != 3'h0 ? gsub : ctl[c][7:5];
		if (k == 3'h1) b = dtk[c];
		if (k == 3'h4) b = LOOPB;
		m = {ctl[c][4], {3{ctl[c][2], ctl[c][3]}}, ctl[c][2]};
		g = !(gm && gp) ? 8'h00 : ctl[c][0] ? 8'hff : {7'h0, ctl[c][1]};
		if (gstk || stk[c][4]) s = stk[c][3:0];
		return {k == 3'h2 || k == 3'h3, stk[c][5], g, s, b ^ m};
	endfunction
	task automatic send(input int c, output logic a);
		int n;
		n = 0;
		tx_valid_i <= 1'b1;
		tx_ch_i <= 5'(c);
		// test channels carry the detector's reference stream
		tx_byte_i <= (gmode != 2'h0 && stk[c][6]) ? src[22:15] : 8'($random(seed));
		tx_sig_i <= 4'($random(seed));
		do begin
			@(posedge clk_i);
			n++;
		end while (tx_ready_o !== 1'b1 && n < 40);
		a = tx_ready_o;
		if (a) txq.push_back(texp(c, tx_byte_i, tx_sig_i));
		if (a && gmode != 2'h0 && stk[c][6]) begin
			src = lfsr(src, gmode == 2'h1 ? 8 : 7);
			ndet++;
		end
	endtask
	task automatic cfg(input int p);
		logic [31:0] gw;
		gsub = p == 1 ? 3'h1 : 3'h0;
		gmode = p == 4 ? 2'h1 : p == 5 ? 2'h2 : 2'h0;
		gm = p > 1;
		gp = p == 2;
		gstk = p == 3;
		for (int c = 0; c < 24; c++) begin
			ctl[c] = {3'(c), 5'($random(seed))};
			dtk[c] = 8'($random(seed));
			stk[c] = 8'($random(seed));
			if (p > 3) stk[c][6] = 1'b1;
			rtk[c] = 8'($random(seed));
			wb(1'b1, 9'(9'h01 + c), 32'(ctl[c]));
			wb(1'b1, 9'(9'h21 + c), 32'(dtk[c]));
			wb(1'b1, 9'(9'h41 + c), 32'(stk[c]));
			wb(1'b1, 9'(9'h141 + c), 32'(rtk[c]));
			wb(1'b1, 9'(9'h121 + c), 32'(dtk[c] ^ 8'hff));
			rdchk("rx trunk", 9'(9'h121 + c), dtk[c] ^ 8'hff);
			stk[c] &= 8'h7f;
			rtk[c] &= 8'h5f;
			rdchk("ctrl", 9'(9'h01 + c), ctl[c]);
			rdchk("trunk", 9'(9'h21 + c), dtk[c]);
			rdchk("sig trunk", 9'(9'h41 + c), stk[c]);
			rdchk("rx sig trunk", 9'(9'h141 + c), rtk[c]);
		end
		gw = {20'h0, gp, gm, 2'h3, 1'b0, gstk, 1'b0, gmode, gsub};
		wb(1'b1, 9'h0f0, gw);
		wb(1'b0, 9'h0f0, 32'h0);
		chk("global", gw, rd);
	endtask
	task automatic run(input int k);
		int n;
		n = 0;
		rxon = 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < k; i++) send({$random(seed)} % 24, ok);
		tx_valid_i <= 1'b0;
		rxon = 1'b0;
		repeat (2) @(posedge clk_i);
		while ((txq.size() != 0 || rxq.size() != 0) && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("tx left", 32'h0, 32'(txq.size()));
		chk("prbs bytes", 32'(ndet), 32'(npv));
		if (gmode != 2'h0) begin
			chk("prbs sync", 32'h1, 32'(psync));
			chk("prbs error", 32'h0, 32'(pbit));
		end
	endtask
	always @(posedge clk_i) begin
		if (rx_valid_i === 1'b1) begin
			rb = rx_byte_i;
			if (gmode != 2'h0 && rtk[rx_ch_i][6]) begin
				// overwrite channels take the next generator bits in arrival order
				pl = gmode == 2'h1 ? 8'hff : 8'hfe;
				rb = (rb & ~pl) | (gen[22:15] & pl);
				gen = lfsr(gen, gmode == 2'h1 ? 8 : 7);
			end
			rxq.push_back({rb, gstk || rtk[rx_ch_i][4] ? rtk[rx_ch_i][3:0] : rx_sig_i});
		end
		if (rx_valid_o === 1'b1) begin
			re = rxq.pop_front();
			chk("rx byte", 32'(re[11:4]), 32'(rx_byte_o));
			chk("rx sig", 32'(re[3:0]), 32'(rx_sig_o));
		end
		rx_valid_i <= rxon && $random(seed) % 2 != 0;
		rx_ch_i <= 5'({$random(seed)} % 24);
		rx_byte_i <= 8'($random(seed));
		rx_sig_i <= 4'($random(seed));
	end
	always @(posedge clk_i) begin
		if (pvld === 1'b1) npv++;
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
			te = txq.pop_front();
			if (!te[21]) chk("tx byte", 32'(te[7:0]), 32'(tx_byte_o));
			chk("tx sig", 32'(te[11:8]), 32'(tx_sig_o));
			chk("tx insert", 32'(te[20]), 32'(tx_sig_ins_o));
			chk("tx gap", 32'(te[19:12]), 32'(tx_clk_gap_o));
		end
	end
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		final_report;
	end
	initial begin
		seed = 32'h3b033126;
		err_total = 0;
		n_checks = 0;
		ndet = 0;
		npv = 0;
		{cyc_i, stb_i, we_i, tx_valid_i, rx_valid_i, hold, rxon} = '0;
		{sel_i, adr_i, dat_i, tx_ch_i, tx_byte_i, tx_sig_i} = '0;
		{rx_ch_i, rx_byte_i, rx_sig_i} = '0;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("reset ctrl", 9'h001, 8'h00);
		rdchk("reset trunk", 9'h021, 8'h00);
		rdchk("reset sig", 9'h141, 8'h00);
		wb(1'b1, 9'h019, 32'hff);
		rdchk("unmapped", 9'h019, 8'h00);
		for (int p = 0; p < 6; p++) begin
			cfg(p);
			run(60);
		end
		// stall the far side until the buffer refuses, then drain
		hold <= 1'b1;
		cnt = 0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 7; i++) begin
			send(i, ok);
			cnt += int'(ok);
		end
		chk("accepted", 32'h5, 32'(cnt));
		chk("ready full", 32'h0, 32'(tx_ready_o));
		hold <= 1'b0;
		run(8);
		final_report;
	end
endmodule // test_tpcc_top
